// File: hw/rtv_bcd_pair.sv
// two-digit bcd counter with load, wrap point and carry out
`timescale 1ns/1ps
module rtv_bcd_pair #(
	parameter int TENS_W = 3,
	parameter int TENS_MAX = 5,
	parameter int ONES_LAST = 9
) (
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic inc_i,
	input wire logic load_i,
	input wire logic [7:0] load_val_i,
	output logic [7:0] value_o,
	output logic carry_o
);
	localparam int PAD_W = 8 - rtv_pkg::ONES_W - TENS_W;
	localparam logic [TENS_W-1:0] TENS_LAST = TENS_W'(TENS_MAX);
	localparam logic [3:0] ONES_WRAP = 4'(ONES_LAST);
	localparam logic [TENS_W-1:0] TENS_ONE = TENS_W'(1);

	// no reset: contents stay undefined until software loads them
	logic [3:0] ones_reg;
	logic [TENS_W-1:0] tens_reg;
	logic [3:0] ones_next;
	logic [TENS_W-1:0] tens_next;

	wire ones_full = ones_reg >= rtv_pkg::ONES_MAX;
	wire at_last = (tens_reg == TENS_LAST) && (ones_reg == ONES_WRAP);
	wire do_inc = inc_i & ~load_i;

	assign carry_o = do_inc & at_last;
	assign value_o = {{PAD_W{1'b0}}, tens_reg, ones_reg};

	always_comb begin
		ones_next = ones_reg;
		tens_next = tens_reg;
		if (load_i) begin
			ones_next = load_val_i[rtv_pkg::ONES_LSB +: rtv_pkg::ONES_W];
			tens_next = load_val_i[rtv_pkg::TENS_LSB +: TENS_W];
		end else if (do_inc) begin
			if (at_last) begin
				ones_next = '0;
				tens_next = '0;
			end else if (ones_full) begin
				ones_next = '0;
				tens_next = tens_reg + TENS_ONE;
			end else begin
				ones_next = ones_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			ones_reg <= ones_next;
			tens_reg <= tens_next;
		end
	end

endmodule : rtv_bcd_pair

// File: hw/rtv_pkg.sv
// constants, field layouts and types shared by the time and alarm register block
package rtv_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [3:0] OFS_CLOCK_CFG = 4'h0;
	localparam logic [3:0] OFS_ALARM_CFG = 4'h1;
	localparam logic [3:0] OFS_TIME_WIN_HIGH = 4'h2;
	localparam logic [3:0] OFS_TIME_WIN_LOW = 4'h3;
	localparam logic [3:0] OFS_ALARM_WIN_HIGH = 4'h4;
	localparam logic [3:0] OFS_ALARM_WIN_LOW = 4'h5;
	localparam logic [3:0] OFS_UNLOCK_KEY = 4'h6;

	// clock_config_register and alarm config fields
	localparam int CFG_CLOCK_ENABLE_BIT = 7;
	localparam int CFG_WRITE_ENABLE_BIT = 5;
	localparam int PTR_LSB = 0;
	localparam int PTR_W = 2;

	localparam logic CTRL_BIT_RST = 1'h0;
	localparam logic [1:0] PTR_RST = 2'h0;
	localparam logic [1:0] PTR_ZERO = 2'h0;
	localparam logic [1:0] PTR_STEP = 2'h1;
	localparam logic [7:0] DATA_ZERO = 8'h00;

	// window pointer selections
	localparam logic [1:0] PTR_MIN_SEC = 2'h0;
	localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR = 2'h1;
	localparam logic [1:0] PTR_MONTH_DAY = 2'h2;

	// unlock sequence
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam int UNLOCK_WINDOW_CYC = 1;

	// bcd digit layout
	localparam int ONES_W = 4;
	localparam int ONES_LSB = 0;
	localparam int TENS_LSB = 4;
	localparam logic [3:0] ONES_MAX = 4'h9;
	localparam int HOUR_TENS_W = 2;
	localparam int HOUR_TENS_MAX = 2;
	localparam int HOUR_ONES_LAST = 3;
	localparam int MS_TENS_W = 3;
	localparam int MS_TENS_MAX = 5;
	localparam int MS_ONES_LAST = 9;

	// writable bits of each value register
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_MIN_SEC = 8'h7F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_DAY = 8'h3F;
	localparam logic [7:0] MASK_WEEKDAY_DIGIT = 8'h07;

	typedef enum logic [2:0] {
		RTV_FLD_HOUR,
		RTV_FLD_MIN_SEC,
		RTV_FLD_MONTH,
		RTV_FLD_DAY,
		RTV_FLD_WEEKDAY_DIGIT
	} rtv_field_t;

	function automatic logic [7:0] rtv_field_mask(input rtv_field_t kind, input logic [7:0] v);
		logic [7:0] m;
		m = DATA_ZERO;
		unique case (kind)
			RTV_FLD_HOUR: m = MASK_HOUR;
			RTV_FLD_MIN_SEC: m = MASK_MIN_SEC;
			RTV_FLD_MONTH: m = MASK_MONTH;
			RTV_FLD_DAY: m = MASK_DAY;
			RTV_FLD_WEEKDAY_DIGIT: m = MASK_WEEKDAY_DIGIT;
		endcase
		return v & m;
	endfunction : rtv_field_mask

endpackage : rtv_pkg

// File: hw/rtv_time_alarm.sv
// current-time and alarm value registers with write lock and bcd counting
`timescale 1ns/1ps
module rtv_time_alarm #(
	parameter int ADDR_W = rtv_pkg::ADDR_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic sec_tick_i,
	output logic clock_enable_o,
	output logic timer_write_enable_o,
	output logic day_carry_o
);

	// bus decode
	wire hit_cfg = addr_i == ADDR_W'(rtv_pkg::OFS_CLOCK_CFG);
	wire hit_alcfg = addr_i == ADDR_W'(rtv_pkg::OFS_ALARM_CFG);
	wire hit_twh = addr_i == ADDR_W'(rtv_pkg::OFS_TIME_WIN_HIGH);
	wire hit_twl = addr_i == ADDR_W'(rtv_pkg::OFS_TIME_WIN_LOW);
	wire hit_awh = addr_i == ADDR_W'(rtv_pkg::OFS_ALARM_WIN_HIGH);
	wire hit_awl = addr_i == ADDR_W'(rtv_pkg::OFS_ALARM_WIN_LOW);
	wire hit_key = addr_i == ADDR_W'(rtv_pkg::OFS_UNLOCK_KEY);

	wire cfg_wr = wr_i & hit_cfg;
	wire alcfg_wr = wr_i & hit_alcfg;
	wire twh_wr = wr_i & hit_twh;
	wire twl_wr = wr_i & hit_twl;
	wire awh_wr = wr_i & hit_awh;
	wire awl_wr = wr_i & hit_awl;
	wire key_wr = wr_i & hit_key;
	wire twh_acc = (wr_i | rd_i) & hit_twh;
	wire awh_acc = (wr_i | rd_i) & hit_awh;

	// control state
	logic clock_enable_reg;
	logic timer_write_enable_reg;
	logic [1:0] time_ptr_reg;
	logic [1:0] alarm_ptr_reg;
	logic clock_enable_next;
	logic timer_write_enable_next;
	logic [1:0] time_ptr_next;
	logic [1:0] alarm_ptr_next;
	logic unlock_open;

	rtv_unlock u_unlock (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.key_wr_i(key_wr),
		.key_i(wdata_i),
		.open_o(unlock_open)
	);

	wire wren_req = wdata_i[rtv_pkg::CFG_WRITE_ENABLE_BIT];
	wire [1:0] ptr_wval = wdata_i[rtv_pkg::PTR_LSB +: rtv_pkg::PTR_W];

	always_comb begin
		clock_enable_next = clock_enable_reg;
		timer_write_enable_next = timer_write_enable_reg;
		time_ptr_next = time_ptr_reg;
		alarm_ptr_next = alarm_ptr_reg;
		if (cfg_wr) begin
			// clearing is always allowed; setting needs the open key window
			timer_write_enable_next = wren_req & (unlock_open | timer_write_enable_reg);
			if (timer_write_enable_reg)
				clock_enable_next = wdata_i[rtv_pkg::CFG_CLOCK_ENABLE_BIT];
			time_ptr_next = ptr_wval;
		end
		if (alcfg_wr)
			alarm_ptr_next = ptr_wval;
		if (twh_acc && time_ptr_reg != rtv_pkg::PTR_ZERO)
			time_ptr_next = time_ptr_reg - rtv_pkg::PTR_STEP;
		if (awh_acc && alarm_ptr_reg != rtv_pkg::PTR_ZERO)
			alarm_ptr_next = alarm_ptr_reg - rtv_pkg::PTR_STEP;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clock_enable_reg <= rtv_pkg::CTRL_BIT_RST;
			timer_write_enable_reg <= rtv_pkg::CTRL_BIT_RST;
			time_ptr_reg <= rtv_pkg::PTR_RST;
			alarm_ptr_reg <= rtv_pkg::PTR_RST;
		end else if (ce_i) begin
			clock_enable_reg <= clock_enable_next;
			timer_write_enable_reg <= timer_write_enable_next;
			time_ptr_reg <= time_ptr_next;
			alarm_ptr_reg <= alarm_ptr_next;
		end
	end

	assign clock_enable_o = clock_enable_reg;
	assign timer_write_enable_o = timer_write_enable_reg;

	// time window writes, all behind the lock
	wire twh_ok = twh_wr & timer_write_enable_reg;
	wire twl_ok = twl_wr & timer_write_enable_reg;
	wire tptr_ms = time_ptr_reg == rtv_pkg::PTR_MIN_SEC;
	wire tptr_wh = time_ptr_reg == rtv_pkg::PTR_WEEKDAY_DIGIT_HOUR;
	wire load_min = twh_ok & tptr_ms;
	wire load_sec = twl_ok & tptr_ms;
	wire load_hour = twl_ok & tptr_wh;

	wire [7:0] wval_hour = rtv_pkg::rtv_field_mask(rtv_pkg::RTV_FLD_HOUR, wdata_i);
	wire [7:0] wval_ms = rtv_pkg::rtv_field_mask(rtv_pkg::RTV_FLD_MIN_SEC, wdata_i);

	// counting chain; a load in the same cycle takes the place of the step
	wire tick_inc = sec_tick_i & clock_enable_reg;
	logic sec_carry;
	logic min_carry;
	logic hour_carry;
	logic [7:0] second_value;
	logic [7:0] minute_value;
	logic [7:0] hour_value;

	rtv_bcd_pair #(
		.TENS_W(rtv_pkg::MS_TENS_W),
		.TENS_MAX(rtv_pkg::MS_TENS_MAX),
		.ONES_LAST(rtv_pkg::MS_ONES_LAST)
	) u_second (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.inc_i(tick_inc),
		.load_i(load_sec),
		.load_val_i(wval_ms),
		.value_o(second_value),
		.carry_o(sec_carry)
	);

	rtv_bcd_pair #(
		.TENS_W(rtv_pkg::MS_TENS_W),
		.TENS_MAX(rtv_pkg::MS_TENS_MAX),
		.ONES_LAST(rtv_pkg::MS_ONES_LAST)
	) u_minute (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.inc_i(sec_carry),
		.load_i(load_min),
		.load_val_i(wval_ms),
		.value_o(minute_value),
		.carry_o(min_carry)
	);

	rtv_bcd_pair #(
		.TENS_W(rtv_pkg::HOUR_TENS_W),
		.TENS_MAX(rtv_pkg::HOUR_TENS_MAX),
		.ONES_LAST(rtv_pkg::HOUR_ONES_LAST)
	) u_hour (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.inc_i(min_carry),
		.load_i(load_hour),
		.load_val_i(wval_hour),
		.value_o(hour_value),
		.carry_o(hour_carry)
	);

	// alarm window writes: minute and second are not locked
	wire aptr_ms = alarm_ptr_reg == rtv_pkg::PTR_MIN_SEC;
	wire aptr_wh = alarm_ptr_reg == rtv_pkg::PTR_WEEKDAY_DIGIT_HOUR;
	wire aptr_md = alarm_ptr_reg == rtv_pkg::PTR_MONTH_DAY;
	wire awr_min = awh_wr & aptr_ms;
	wire awr_sec = awl_wr & aptr_ms;
	wire awr_weekday_digit = awh_wr & aptr_wh & timer_write_enable_reg;
	wire awr_hour = awl_wr & aptr_wh & timer_write_enable_reg;
	wire awr_month = awh_wr & aptr_md & timer_write_enable_reg;
	wire awr_day = awl_wr & aptr_md & timer_write_enable_reg;

	// no reset on purpose: software initialises the alarm values
	logic [7:0] alarm_month_value_reg;
	logic [7:0] alarm_day_value_reg;
	logic [7:0] alarm_weekday_value_reg;
	logic [7:0] alarm_hour_value_reg;
	logic [7:0] alarm_minute_value_reg;
	logic [7:0] alarm_second_value_reg;

	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			if (awr_month)
				alarm_month_value_reg <= rtv_pkg::rtv_field_mask(rtv_pkg::RTV_FLD_MONTH, wdata_i);
			if (awr_day)
				alarm_day_value_reg <= rtv_pkg::rtv_field_mask(rtv_pkg::RTV_FLD_DAY, wdata_i);
			if (awr_weekday_digit)
				alarm_weekday_value_reg <= rtv_pkg::rtv_field_mask(rtv_pkg::RTV_FLD_WEEKDAY_DIGIT, wdata_i);
			if (awr_hour)
				alarm_hour_value_reg <= wval_hour;
			if (awr_min)
				alarm_minute_value_reg <= wval_ms;
			if (awr_sec)
				alarm_second_value_reg <= wval_ms;
		end
	end

	// read selection; unmapped slots and date fields held elsewhere read zero
	logic [7:0] rd_mux;
	logic [7:0] cfg_view;
	logic [7:0] alcfg_view;

	always_comb begin
		cfg_view = rtv_pkg::DATA_ZERO;
		cfg_view[rtv_pkg::CFG_CLOCK_ENABLE_BIT] = clock_enable_reg;
		cfg_view[rtv_pkg::CFG_WRITE_ENABLE_BIT] = timer_write_enable_reg;
		cfg_view[rtv_pkg::PTR_LSB +: rtv_pkg::PTR_W] = time_ptr_reg;
		alcfg_view = rtv_pkg::DATA_ZERO;
		alcfg_view[rtv_pkg::PTR_LSB +: rtv_pkg::PTR_W] = alarm_ptr_reg;
	end

	always_comb begin
		rd_mux = rtv_pkg::DATA_ZERO;
		if (hit_cfg)
			rd_mux = cfg_view;
		else if (hit_alcfg)
			rd_mux = alcfg_view;
		else if (hit_twh && tptr_ms)
			rd_mux = minute_value;
		else if (hit_twl && tptr_ms)
			rd_mux = second_value;
		else if (hit_twl && tptr_wh)
			rd_mux = hour_value;
		else if (hit_awh && aptr_ms)
			rd_mux = alarm_minute_value_reg;
		else if (hit_awh && aptr_wh)
			rd_mux = alarm_weekday_value_reg;
		else if (hit_awh && aptr_md)
			rd_mux = alarm_month_value_reg;
		else if (hit_awl && aptr_ms)
			rd_mux = alarm_second_value_reg;
		else if (hit_awl && aptr_wh)
			rd_mux = alarm_hour_value_reg;
		else if (hit_awl && aptr_md)
			rd_mux = alarm_day_value_reg;
	end

	// read data stand one cycle after the strobe and only then
	logic [7:0] rdata_reg;
	logic day_carry_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= rtv_pkg::DATA_ZERO;
			day_carry_reg <= rtv_pkg::CTRL_BIT_RST;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rd_mux : rtv_pkg::DATA_ZERO;
			day_carry_reg <= hour_carry;
		end
	end

	assign rdata_o = rdata_reg;
	assign day_carry_o = day_carry_reg;

endmodule : rtv_time_alarm

// File: hw/rtv_unlock.sv
// two-write key sequence that opens a short window for setting the write enable
`timescale 1ns/1ps
module rtv_unlock (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic key_wr_i,
	input wire logic [7:0] key_i,
	output logic open_o
);
	typedef enum logic [1:0] {RTV_UL_IDLE, RTV_UL_ARMED, RTV_UL_OPEN} rtv_ul_state_t;

	localparam int CNT_W = $clog2(rtv_pkg::UNLOCK_WINDOW_CYC + 1);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(rtv_pkg::UNLOCK_WINDOW_CYC - 1);

	rtv_ul_state_t state_reg;
	rtv_ul_state_t state_next;
	logic [CNT_W-1:0] win_cnt_reg;
	logic [CNT_W-1:0] win_cnt_next;

	wire got_first = key_wr_i && (key_i == rtv_pkg::KEY_FIRST);
	wire got_second = key_wr_i && (key_i == rtv_pkg::KEY_SECOND);

	assign open_o = (state_reg == RTV_UL_OPEN);

	always_comb begin
		state_next = state_reg;
		win_cnt_next = win_cnt_reg;
		unique case (state_reg)
			RTV_UL_IDLE: begin
				if (got_first)
					state_next = RTV_UL_ARMED;
			end
			RTV_UL_ARMED: begin
				if (got_second) begin
					state_next = RTV_UL_OPEN;
					win_cnt_next = '0;
				end else if (!got_first && key_wr_i) begin
					state_next = RTV_UL_IDLE;
				end
			end
			RTV_UL_OPEN: begin
				// window is counted in clocks with ce_i high and closes whatever the bus does
				if (win_cnt_reg == WIN_LAST)
					state_next = got_first ? RTV_UL_ARMED : RTV_UL_IDLE;
				else
					win_cnt_next = win_cnt_reg + CNT_W'(1);
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= RTV_UL_IDLE;
			win_cnt_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
			win_cnt_reg <= win_cnt_next;
		end
	end

endmodule : rtv_unlock

// File: tb/rtv_time_alarm_assertions.sv
// concurrent checks on the ports of the time and alarm register block
`timescale 1ns/1ps
module rtv_time_alarm_assertions #(
	parameter int ADDR_W = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic sec_tick_i,
	input wire logic clock_enable_o,
	input wire logic timer_write_enable_o,
	input wire logic day_carry_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire cfg_wr = wr_i && ce_i && addr_i == rtv_pkg::OFS_CLOCK_CFG;
	wire cfg_rd = rd_i && ce_i && addr_i == rtv_pkg::OFS_CLOCK_CFG;
	wire key_wr = wr_i && ce_i && addr_i == rtv_pkg::OFS_UNLOCK_KEY;
	wire win_rd = rd_i && ce_i && addr_i >= rtv_pkg::OFS_TIME_WIN_HIGH
		&& addr_i <= rtv_pkg::OFS_ALARM_WIN_LOW;
	sequence key_pair_s;
		key_wr && wdata_i == rtv_pkg::KEY_FIRST ##1 key_wr && wdata_i == rtv_pkg::KEY_SECOND;
	endsequence
	sequence unlock_s;
		key_pair_s ##1 cfg_wr && wdata_i[5];
	endsequence
	unlock_open_a: assert property (unlock_s |=> timer_write_enable_o)
		else $error("write enable not set after key sequence");
	wren_rise_a: assert property ($rose(timer_write_enable_o) |-> $past(cfg_wr && wdata_i[5])
		&& $past(key_wr && wdata_i == rtv_pkg::KEY_SECOND, 2))
		else $error("write enable set without key sequence");
	clken_lock_a: assert property (cfg_wr && !timer_write_enable_o |=> $stable(clock_enable_o))
		else $error("clock enable changed while locked");
	clken_write_a: assert property (cfg_wr && timer_write_enable_o
		|=> clock_enable_o == $past(wdata_i[7]))
		else $error("clock enable not taken from unlocked write");
	cfg_read_a: assert property (cfg_rd |=> rdata_o[7] == $past(clock_enable_o)
		&& rdata_o[5] == $past(timer_write_enable_o))
		else $error("config read disagrees with enable outputs");
	unmapped_read_a: assert property (rd_i && ce_i && addr_i > rtv_pkg::OFS_UNLOCK_KEY
		|=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	value_top_a: assert property (win_rd |=> !rdata_o[7])
		else $error("value register top bit not zero");
	rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	carry_pulse_a: assert property (day_carry_o |=> !day_carry_o)
		else $error("day carry longer than one cycle");
	carry_cause_a: assert property ($rose(day_carry_o) |-> $past(sec_tick_i)
		|| $past(sec_tick_i, 2))
		else $error("day carry without a count pulse");
endmodule : rtv_time_alarm_assertions

bind rtv_time_alarm rtv_time_alarm_assertions #(.ADDR_W(ADDR_W)) u_rtv_chk (.sys_clk_i, .rst_i,
	.ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sec_tick_i, .clock_enable_o,
	.timer_write_enable_o, .day_carry_o);

// File: tb/rtv_time_alarm_tb.sv
// self-checking bench for the time and alarm register block
`timescale 1ns/1ps
module rtv_time_alarm_tb;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic sec_tick_i = 1'b0;
	logic [7:0] rdata_o;
	logic clock_enable_o;
	logic timer_write_enable_o;
	logic day_carry_o;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic rd_seen = 1'b0;
	logic [7:0] carries = 8'h00;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [15:0] seed = 16'h732A;
	logic [7:0] val [12];
	// cfg rows (offset 0 or 1) carry the cfg byte; value rows carry the implemented-bit mask
	localparam logic [3:0] TA [12] = '{4'h0, 4'h3, 4'h2, 4'h2, 4'h3, 4'h1, 4'h5, 4'h4, 4'h5,
		4'h4, 4'h4, 4'h5};
	localparam logic [7:0] TM [12] = '{8'h21, 8'h3F, 8'h00, 8'h7F, 8'h7F, 8'h02, 8'h3F, 8'h1F,
		8'h3F, 8'h07, 8'h7F, 8'h7F};

	rtv_time_alarm u_rtv_time_alarm (.sys_clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .sec_tick_i, .clock_enable_o, .timer_write_enable_o, .day_carry_o);

	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk_i) begin
		if (rd_seen && exp_q.size() > 0) cmp_byte(rdata_o & msk_q.pop_front(), exp_q.pop_front());
		rd_seen <= rd_i && ce_i;
		if (day_carry_o === 1'b1) carries <= carries + 8'h01;
	end

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end

	function automatic logic [15:0] xs(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction : xs

	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= r;
		@(posedge sys_clk_i);
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd

	task automatic unlock(input int gap, input logic [7:0] cfg);
		wr(4'h6, 8'h55);
		wr(4'h6, 8'hAA);
		repeat (gap) bus(1'b0, 1'b0, 4'h0, 8'h00);
		wr(4'h0, cfg);
	endtask : unlock

	task automatic tick();
		sec_tick_i <= 1'b1;
		bus(1'b0, 1'b0, 4'h0, 8'h00);
		sec_tick_i <= 1'b0;
	endtask : tick

	initial begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rd(4'h0, 8'h00, 8'hA3);
		wr(4'h0, 8'hA0);
		rd(4'h0, 8'h00, 8'hA0);
		unlock(1, 8'h20);
		rd(4'h0, 8'h00, 8'h20);
		unlock(0, 8'h20);
		rd(4'h0, 8'h20, 8'h20);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 12; i++) begin
				seed = xs(seed);
				val[i] = (p == 0) ? 8'hFF : seed[7:0];
				wr(TA[i], (TA[i] <= 4'h1) ? TM[i] : val[i]);
			end
			for (int i = 0; i < 12; i++) begin
				if (TA[i] <= 4'h1) wr(TA[i], TM[i]);
				else rd(TA[i], val[i] & TM[i], 8'hFF);
			end
		end
		wr(4'h0, 8'h01);
		wr(4'h3, 8'h05);
		wr(4'h0, 8'h80);
		wr(4'h2, 8'h11);
		wr(4'h3, 8'h22);
		wr(4'h1, 8'h01);
		wr(4'h5, 8'h11);
		rd(4'h0, 8'h00, 8'hA0);
		rd(4'h2, val[3] & 8'h7F, 8'hFF);
		rd(4'h3, val[4] & 8'h7F, 8'hFF);
		rd(4'h5, val[8] & 8'h3F, 8'hFF);
		wr(4'h0, 8'h01);
		rd(4'h3, val[1] & 8'h3F, 8'hFF);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00, 8'hFF);
		rd(4'h9, 8'h00, 8'hFF);
		unlock(0, 8'h21);
		wr(4'h3, 8'h23);
		wr(4'h2, 8'h00);
		wr(4'h2, 8'h59);
		wr(4'h3, 8'h58);
		tick();
		rd(4'h3, 8'h58, 8'hFF);
		wr(4'h0, 8'hA0);
		tick();
		rd(4'h3, 8'h59, 8'hFF);
		tick();
		repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
		rd(4'h2, 8'h00, 8'hFF);
		rd(4'h3, 8'h00, 8'hFF);
		wr(4'h0, 8'hA1);
		rd(4'h3, 8'h00, 8'hFF);
		wr(4'h0, 8'hA0);
		wr(4'h3, 8'h09);
		tick();
		rd(4'h3, 8'h10, 8'hFF);
		// a write while the clock enable input is low must leave the second untouched
		ce_i <= 1'b0;
		wr(4'h3, 8'h33);
		ce_i <= 1'b1;
		rd(4'h3, 8'h10, 8'hFF);
		repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
		cmp_byte(carries, 8'h01);
		final_report();
	end
endmodule : rtv_time_alarm_tb
